/* File: inc/dsbr_defines.svh */
// Constants of the drive status byte readout block
// Overview of operation
// R1 - Firmware trace codes are kept in a sixteen-byte wrap-around store, one per recorded event.
// R2 - Each trace-code read returns one stored code, oldest first, and removes it.
// R3 - A fault clear command discards every stored trace code at once.
// R4 - Bits seven to four of the identification byte carry a fixed four-bit identity code.
// R5 - Bits three to zero of the identification byte give one for 64 and zero for 32 sectors.
// R6 - The identification send request is raised only when the send-identity bit arrives.
// R7 - Status bit zero shows the cartridge tab, which blocks writes on heads zero and one.
// R8 - Status bit one shows the fixed switch, which blocks writes on heads two and three.
// R9 - Status bits two, three and four always read as zero.
// R10 - Status bit five is set only while spindle speed is within limits.
// R11 - Status bit six is set once the spindle has stopped after power-off or stop switch.
// R12 - Status bit seven is set, and spindle start is held off, on stop, no cartridge or open door.
// R13 - The auxiliary byte holds the cylinder value given in the latest loopback command.
// R14 - Byte address zero is identification, one trace code, two status, three auxiliary.
// R15 - A loopback command first asks for the low cylinder byte, then offers it back.
// R16 - A fault clear that comes with other events clears the trace store first.
// R17 - A new code written into a full store overwrites the oldest entry.
`ifndef DSBR_DEFINES_SVH
`define DSBR_DEFINES_SVH

// ********************************
// Byte addresses
// ********************************
`define DSBR_ADDR_ID      3'h0
`define DSBR_ADDR_TRACE   3'h1
`define DSBR_ADDR_FLAGS   3'h2
`define DSBR_ADDR_ECHO    3'h3
`define DSBR_ADDR_LOWCYL  3'h6

// ********************************
// Fields and values
// ********************************
`define DSBR_EXT_SEND_ID  2
`define DSBR_CFG_64SEC    4'h1
`define DSBR_CFG_32SEC    4'h0
`define DSBR_TRACE_DEPTH  5'h10
`define DSBR_TRACE_EMPTY  8'h00
`define DSBR_BYTE_RESET   8'h00
`define DSBR_HEAD_FIXED   2'h2

`endif

/* File: inc/dsbr_pkg.sv */
// Types of the drive status byte readout block
package dsbr_pkg;

  // ********************************
  // Carriers
  // ********************************
  typedef struct packed {
    logic cart_tab;
    logic fixed_switch;
  } dsbr_protect_s;

  typedef struct packed {
    logic panel_stop;
    logic cart_absent;
    logic door_open;
    logic speed_ok;
    logic rotation_zero;
  } dsbr_spindle_s;

  // ********************************
  // Loopback sequence
  // ********************************
  typedef enum logic [1:0] {
    LB_IDLE,
    LB_WAIT_CYL,
    LB_OFFER
  } dsbr_loop_e;

endpackage

/* File: rtl/dsbr_trace_ring.sv */
// Wrap-around store for firmware trace codes
`timescale 1ns/10ps
`include "dsbr_defines.svh"
module dsbr_trace_ring
  import dsbr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clear,
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  input  wire logic       pop,
  output logic      [7:0] head_data,
  output logic            empty,
  output logic      [4:0] count
);

  logic [7:0] mem [0:15];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [3:0] base_wr;
  logic [3:0] base_rd;
  logic [4:0] base_cnt;
  logic       do_pop;
  logic [3:0] rd_after_pop;
  logic [4:0] cnt_after_pop;
  logic       overwrite;

  // Clear acts first so a code pushed with it survives
  assign base_wr       = clear ? 4'h0 : wr_ptr;                               // R3 R16
  assign base_rd       = clear ? 4'h0 : rd_ptr;                               // R3 R16
  assign base_cnt      = clear ? 5'h00 : count;                               // R3 R16
  assign do_pop        = pop & ~clear & (count != 5'h00);                     // R2
  assign rd_after_pop  = do_pop ? base_rd + 4'h1 : base_rd;                   // R2
  assign cnt_after_pop = do_pop ? base_cnt - 5'h01 : base_cnt;
  assign overwrite     = push & (cnt_after_pop == `DSBR_TRACE_DEPTH);         // R17
  assign head_data     = mem[rd_ptr];
  assign empty         = (count == 5'h00);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[base_wr] <= push_data;                                              // R1
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count  <= 5'h00;
    end else begin
      wr_ptr <= push ? base_wr + 4'h1 : base_wr;                              // R1
      rd_ptr <= overwrite ? rd_after_pop + 4'h1 : rd_after_pop;               // R17
      count  <= (push & ~overwrite) ? cnt_after_pop + 5'h01 : cnt_after_pop;
    end
  end

endmodule

/* File: rtl/dsbr_readout.sv */
// Drive-side readable bytes: trace codes, identity, hardware flags, loopback echo
`timescale 1ns/10ps
`include "dsbr_defines.svh"
module dsbr_readout
  import dsbr_pkg::*;
#(
  // Identity code value is arbitrary
  parameter logic [3:0] DEV_IDENTITY = 4'hA
)
(
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          rd_strobe,
  input  wire logic    [2:0] rd_addr,
  input  wire logic          wr_strobe,
  input  wire logic    [2:0] wr_addr,
  input  wire logic    [7:0] bus_in,
  output logic         [7:0] bus_out,
  output logic               bus_oe_n,
  output logic               rd_ack,
  input  wire logic          ext_valid,
  input  wire logic    [7:0] ext_byte,
  input  wire logic          loop_cmd,
  input  wire logic          fault_clear,
  input  wire logic          trace_push,
  input  wire logic    [7:0] fault_trace_code,
  input  wire logic          sector64_strap,
  input  wire dsbr_protect_s prot,
  input  wire logic    [1:0] head_sel,
  input  wire dsbr_spindle_s spin,
  input  wire logic          spindle_off_cmd,
  input  wire logic          spindle_on_cmd,
  output logic               write_block,
  output logic               spindle_inhibit,
  output logic               id_send_req,
  output logic               lowcyl_req,
  output logic               echo_send_req,
  output logic         [4:0] trace_count
);

  // ********************************
  // Declarations
  // ********************************
  logic       [7:0] identity_and_config;
  logic       [7:0] hardware_condition_flags;
  logic       [7:0] loopback_echo;
  logic       [3:0] sector_cfg;
  logic             strap_taken;
  logic             pwroff_seen;
  dsbr_loop_e       lb_state;
  dsbr_loop_e       next_lb_state;
  logic       [7:0] trace_head;
  logic             trace_empty;
  logic       [4:0] ring_count;
  logic       [7:0] fault_trace_entry;
  logic             rd_id;
  logic             rd_trace;
  logic             rd_flags;
  logic             rd_echo;
  logic             wr_lowcyl;
  logic             send_id_seen;
  logic       [7:0] next_bus_out;
  logic       [7:0] next_flags;
  logic             stop_cond;
  logic             head_fixed;
  logic             next_write_block;
  logic             next_id_send_req;
  logic             next_lowcyl_req;
  logic             next_echo_req;
  logic       [7:0] next_echo;

  // ********************************
  // Address decode
  // ********************************
  assign rd_id     = rd_strobe & (rd_addr == `DSBR_ADDR_ID);                  // R14
  assign rd_trace  = rd_strobe & (rd_addr == `DSBR_ADDR_TRACE);               // R14
  assign rd_flags  = rd_strobe & (rd_addr == `DSBR_ADDR_FLAGS);               // R14
  assign rd_echo   = rd_strobe & (rd_addr == `DSBR_ADDR_ECHO);                // R14
  assign wr_lowcyl = wr_strobe & (wr_addr == `DSBR_ADDR_LOWCYL);

  // ********************************
  // Trace store
  // ********************************
  // Each trace read of a non-empty store pops exactly one entry, except in a cycle that also brings a fault clear
  dsbr_trace_ring u_ring (
    .clk       (clk),
    .resetn    (resetn),
    .clear     (fault_clear),                                                 // R3 R16
    .push      (trace_push),                                                  // R1
    .push_data (fault_trace_code),
    .pop       (rd_trace),                                                    // R2
    .head_data (trace_head),
    .empty     (trace_empty),
    .count     (ring_count)
  );

  // An empty store reads as a neutral byte rather than stale memory
  assign fault_trace_entry = trace_empty ? `DSBR_TRACE_EMPTY : trace_head;   // R2

  // ********************************
  // Identity byte
  // ********************************
  // Strap is caught after reset release, never inside the reset branch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_taken <= 1'b0;
      sector_cfg  <= `DSBR_CFG_32SEC;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      sector_cfg  <= sector64_strap ? `DSBR_CFG_64SEC : `DSBR_CFG_32SEC;     // R5
    end
  end

  assign identity_and_config = {DEV_IDENTITY, sector_cfg};                   // R4 R5

  // ********************************
  // Hardware condition flags
  // ********************************
  assign stop_cond  = spin.panel_stop | spin.cart_absent | spin.door_open;   // R12
  assign head_fixed = (head_sel >= `DSBR_HEAD_FIXED);

  assign next_flags = {stop_cond,                                            // R12
                       spin.rotation_zero & pwroff_seen,                     // R11
                       spin.speed_ok,                                        // R10
                       3'h0,                                                 // R9
                       prot.fixed_switch,                                    // R8
                       prot.cart_tab};                                       // R7

  assign next_write_block = head_fixed ? prot.fixed_switch : prot.cart_tab;  // R7 R8

  // Remembers why the spindle stops; a start command forgets it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwroff_seen <= 1'b0;
    end else if (spindle_off_cmd | spin.panel_stop) begin
      pwroff_seen <= 1'b1;                                                   // R11
    end else if (spindle_on_cmd) begin
      pwroff_seen <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hardware_condition_flags <= `DSBR_BYTE_RESET;
      write_block              <= 1'b0;
      spindle_inhibit          <= 1'b0;
    end else begin
      hardware_condition_flags <= next_flags;
      write_block              <= next_write_block;                          // R7 R8
      spindle_inhibit          <= stop_cond;                                 // R12
    end
  end

  // ********************************
  // Identity send request
  // ********************************
  // A new request in the cycle the adapter reads the byte wins over the clear
  assign send_id_seen     = ext_valid & ext_byte[`DSBR_EXT_SEND_ID];         // R6
  assign next_id_send_req = send_id_seen | (id_send_req & ~rd_id);           // R6

  // ********************************
  // Loopback sequence
  // ********************************
  always_comb begin
    next_lb_state   = lb_state;
    next_lowcyl_req = lowcyl_req;
    next_echo_req   = echo_send_req;
    next_echo       = loopback_echo;
    unique case (lb_state)
      LB_IDLE: begin
        if (loop_cmd) begin
          next_lb_state   = LB_WAIT_CYL;                                     // R15
          next_lowcyl_req = 1'b1;
        end
      end
      LB_WAIT_CYL: begin
        if (wr_lowcyl) begin
          next_lb_state   = LB_OFFER;                                        // R15
          next_lowcyl_req = 1'b0;
          next_echo_req   = 1'b1;
          next_echo       = bus_in;                                          // R13
        end
      end
      LB_OFFER: begin
        if (rd_echo) begin
          next_lb_state = LB_IDLE;
          next_echo_req = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lb_state      <= LB_IDLE;
      lowcyl_req    <= 1'b0;
      echo_send_req <= 1'b0;
      loopback_echo <= `DSBR_BYTE_RESET;
      id_send_req   <= 1'b0;
    end else begin
      lb_state      <= next_lb_state;
      lowcyl_req    <= next_lowcyl_req;
      echo_send_req <= next_echo_req;
      loopback_echo <= next_echo;
      id_send_req   <= next_id_send_req;
    end
  end

  // ********************************
  // Read return
  // ********************************
  // Unmapped addresses still answer, with a zero byte, so the adapter never hangs
  assign next_bus_out = rd_id    ? identity_and_config :
                        rd_trace ? fault_trace_entry :
                        rd_flags ? hardware_condition_flags :
                        rd_echo  ? loopback_echo :
                                   `DSBR_BYTE_RESET;                         // R14

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_out     <= `DSBR_BYTE_RESET;
      bus_oe_n    <= 1'b1;
      rd_ack      <= 1'b0;
      trace_count <= 5'h00;
    end else begin
      bus_out     <= rd_strobe ? next_bus_out : `DSBR_BYTE_RESET;
      bus_oe_n    <= ~rd_strobe;
      rd_ack      <= rd_strobe;
      trace_count <= ring_count;
    end
  end

  // ********************************
  // Checks
  // ********************************
  trace_oldest_a: assert property ( // R2
    @(posedge clk) disable iff (!resetn)
    rd_trace && !trace_empty && !fault_clear |=> bus_out == $past(trace_head)
  ) else $error("trace read did not return the oldest entry");

  trace_drain_a: assert property ( // R2
    @(posedge clk) disable iff (!resetn)
    rd_trace && !trace_push && !fault_clear && ring_count != 5'h00
      |=> ring_count == $past(ring_count) - 5'h01
  ) else $error("trace read did not remove one entry");

  trace_clear_a: assert property ( // R3
    @(posedge clk) disable iff (!resetn)
    fault_clear && !trace_push |=> ring_count == 5'h00 ##1 trace_count == 5'h00
  ) else $error("fault clear left trace codes behind");

  trace_cap_a: assert property ( // R17
    @(posedge clk) disable iff (!resetn)
    ring_count == 5'h10 && trace_push && !rd_trace && !fault_clear
      |=> ring_count == 5'h10
  ) else $error("full store did not overwrite in place");

  ident_byte_a: assert property ( // R4
    @(posedge clk) disable iff (!resetn)
    rd_id |=> bus_out[7:4] == DEV_IDENTITY && !bus_oe_n && rd_ack
  ) else $error("identity code missing on bus");

  sector_cfg_a: assert property ( // R5
    @(posedge clk) disable iff (!resetn)
    strap_taken && $past(strap_taken)
      |-> (sector_cfg == 4'h1 || sector_cfg == 4'h0) && $stable(sector_cfg)
  ) else $error("sector configuration changed or illegal");

  id_request_a: assert property ( // R6
    @(posedge clk) disable iff (!resetn)
    !id_send_req && !send_id_seen |=> !id_send_req
  ) else $error("identity request raised without command");

  cart_block_a: assert property ( // R7
    @(posedge clk) disable iff (!resetn)
    prot.cart_tab && head_sel < 2'h2 |=> write_block
  ) else $error("cartridge write not blocked");

  fixed_block_a: assert property ( // R8
    @(posedge clk) disable iff (!resetn)
    prot.fixed_switch && head_sel >= 2'h2 |=> write_block
  ) else $error("fixed media write not blocked");

  flag_reserved_a: assert property ( // R9
    @(posedge clk) disable iff (!resetn)
    rd_flags |=> bus_out[4:2] == 3'h0
  ) else $error("reserved status bits not zero");

  speed_flag_a: assert property ( // R10
    @(posedge clk) disable iff (!resetn)
    hardware_condition_flags[5] |-> $past(spin.speed_ok)
  ) else $error("speed flag set outside limits");

  stopped_flag_a: assert property ( // R11
    @(posedge clk) disable iff (!resetn)
    hardware_condition_flags[6] |-> $past(spin.rotation_zero)
  ) else $error("stopped flag while spindle turns");

  stop_inhibit_a: assert property ( // R12
    @(posedge clk) disable iff (!resetn)
    spin.cart_absent || spin.door_open || spin.panel_stop
      |=> spindle_inhibit && hardware_condition_flags[7]
  ) else $error("spindle not held off");

  echo_hold_a: assert property ( // R13
    @(posedge clk) disable iff (!resetn)
    lb_state == LB_WAIT_CYL && wr_lowcyl |=> loopback_echo == $past(bus_in)
  ) else $error("echo byte does not hold cylinder value");

  loop_order_a: assert property ( // R15
    @(posedge clk) disable iff (!resetn)
    lb_state == LB_IDLE && loop_cmd |=> lowcyl_req && !echo_send_req
  ) else $error("loopback did not ask for low cylinder first");

  loop_offer_a: assert property ( // R15
    @(posedge clk) disable iff (!resetn)
    lb_state == LB_WAIT_CYL && wr_lowcyl |=> echo_send_req && !lowcyl_req
  ) else $error("loopback did not offer the byte back");

  clear_first_a: assert property ( // R16
    @(posedge clk) disable iff (!resetn)
    fault_clear && trace_push && !rd_trace |=> ring_count == 5'h01
  ) else $error("clear did not act before new code");

  unmapped_a: assert property ( // R14
    @(posedge clk) disable iff (!resetn)
    rd_strobe && rd_addr > 3'h3 |=> bus_out == 8'h00 && rd_ack
  ) else $error("unmapped read not zero");

endmodule

/* File: dv/dsbr_adapter_model.sv */
// Adapter controller model driving the command bus of the readout block
`timescale 1ns/10ps
module dsbr_adapter_model (
  input  wire logic       clk,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe_n,
  input  wire logic       rd_ack,
  output logic            rd_strobe,
  output logic      [2:0] rd_addr,
  output logic            wr_strobe,
  output logic      [2:0] wr_addr,
  output logic      [7:0] bus_in,
  output logic            ext_valid,
  output logic      [7:0] ext_byte,
  output logic            loop_cmd
);
  // ****************
  // Idle levels
  // ****************
  // Released data lines float high through the terminators
  initial begin
    rd_strobe = 1'h0;
    rd_addr   = 3'h7;
    wr_strobe = 1'h0;
    wr_addr   = 3'h0;
    bus_in    = 8'hFF;
    ext_valid = 1'h0;
    ext_byte  = 8'hFF;
    loop_cmd  = 1'h0;
  end

  // ****************
  // Bus cycles
  // ****************
  // Data is taken only while the device drives the bus
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    #1;
    rd_strobe = 1'h1;
    rd_addr   = a;
    @(posedge clk);
    #1;
    rd_strobe = 1'h0;
    rd_addr   = ~a;
    n = 0;
    while (rd_ack !== 1'h1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    d = (rd_ack === 1'h1 && bus_oe_n === 1'h0) ? bus_out : 8'hXX;
  endtask

  task automatic wr_low_cyl(input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_strobe = 1'h1;
    wr_addr   = 3'h6;
    bus_in    = d;
    @(posedge clk);
    #1;
    wr_strobe = 1'h0;
    wr_addr   = 3'h0;
    bus_in    = 8'hFF;
  endtask

  task automatic ext(input logic [7:0] b);
    @(posedge clk);
    #1;
    ext_valid = 1'h1;
    ext_byte  = b;
    @(posedge clk);
    #1;
    ext_valid = 1'h0;
    ext_byte  = ~b;
  endtask

  task automatic loop_go();
    @(posedge clk);
    #1;
    loop_cmd = 1'h1;
    @(posedge clk);
    #1;
    loop_cmd = 1'h0;
  endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking testbench of the drive status byte readout block
`timescale 1ns/10ps
`include "dsbr_defines.svh"
module tb_top;
  import dsbr_pkg::*;
  localparam logic [3:0] ID_CODE = 4'h5; // Arbitrary identity value
  logic          clk, resetn, rd_strobe, wr_strobe, rd_ack, bus_oe_n;
  logic    [2:0] rd_addr, wr_addr;
  logic    [7:0] bus_in, bus_out, ext_byte, fault_trace_code;
  logic          ext_valid, loop_cmd, fault_clear, trace_push, sector64_strap;
  dsbr_protect_s prot;
  dsbr_spindle_s spin;
  logic    [1:0] head_sel;
  logic          spindle_off_cmd, spindle_on_cmd, write_block, spindle_inhibit;
  logic          id_send_req, lowcyl_req, echo_send_req;
  logic    [4:0] trace_count;
  int            failures, checked, cycles;

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  dsbr_readout #(.DEV_IDENTITY(ID_CODE)) DUT (
    .clk(clk), .resetn(resetn), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe_n(bus_oe_n), .rd_ack(rd_ack), .ext_valid(ext_valid), .ext_byte(ext_byte),
    .loop_cmd(loop_cmd), .fault_clear(fault_clear), .trace_push(trace_push),
    .fault_trace_code(fault_trace_code), .sector64_strap(sector64_strap), .prot(prot),
    .head_sel(head_sel), .spin(spin), .spindle_off_cmd(spindle_off_cmd),
    .spindle_on_cmd(spindle_on_cmd), .write_block(write_block),
    .spindle_inhibit(spindle_inhibit), .id_send_req(id_send_req),
    .lowcyl_req(lowcyl_req), .echo_send_req(echo_send_req), .trace_count(trace_count));

  dsbr_adapter_model adapter (
    .clk(clk), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .rd_ack(rd_ack),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .bus_in(bus_in), .ext_valid(ext_valid), .ext_byte(ext_byte), .loop_cmd(loop_cmd));

  // ****************
  // Helpers
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Generous ceiling; the full sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end

  task automatic push(input logic [7:0] code, input logic clr);
    trace_push       = 1'h1;
    fault_trace_code = code;
    fault_clear      = clr;
    tick(1);
    trace_push  = 1'h0;
    fault_clear = 1'h0;
    tick(1);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_identity(input logic strap);
    logic [7:0] d;
    resetn         = 1'h0;
    sector64_strap = strap;
    tick(12);
    resetn = 1'h1;
    tick(2);
    chk("idle outputs", {bus_oe_n, rd_ack, id_send_req, lowcyl_req, echo_send_req, 3'h0}, 8'h80);
    chk("trace count", {3'h0, trace_count}, 8'h00);
    adapter.rd(`DSBR_ADDR_ID, d);
    chk("identity byte", d, {ID_CODE, strap ? `DSBR_CFG_64SEC : `DSBR_CFG_32SEC});
  endtask

  task automatic t_id_request();
    logic [7:0] d;
    adapter.ext(8'hFB);
    tick(1);
    chk("id request", {7'h0, id_send_req}, 8'h00);
    adapter.ext(8'h04);
    tick(1);
    chk("id request", {7'h0, id_send_req}, 8'h01);
    adapter.rd(`DSBR_ADDR_ID, d);
    chk("id request", {7'h0, id_send_req}, 8'h00);
  endtask

  task automatic t_trace();
    logic [7:0] d;
    for (int i = 1; i <= 3; i++) push(8'hA0 + 8'(i), 1'h0);
    tick(2);
    chk("trace count", {3'h0, trace_count}, 8'h03);
    for (int i = 1; i <= 3; i++) begin
      adapter.rd(`DSBR_ADDR_TRACE, d);
      chk("trace code", d, 8'hA0 + 8'(i));
    end
    adapter.rd(`DSBR_ADDR_TRACE, d);
    chk("empty trace", d, 8'h00);
    for (int i = 0; i <= 16; i++) push(8'h10 + 8'(i), 1'h0);
    tick(2);
    chk("trace count", {3'h0, trace_count}, 8'h10);
    adapter.rd(`DSBR_ADDR_TRACE, d);
    chk("trace wrap", d, 8'h11);
    fault_clear = 1'h1;
    tick(1);
    fault_clear = 1'h0;
    tick(2);
    chk("trace count", {3'h0, trace_count}, 8'h00);
    push(8'h33, 1'h0);
    push(8'h5A, 1'h1);
    tick(2);
    chk("trace count", {3'h0, trace_count}, 8'h01);
    adapter.rd(`DSBR_ADDR_TRACE, d);
    chk("trace code", d, 8'h5A);
  endtask

  // Each row: command pulse, protect, head, spindle, write block, inhibit, flags
  task automatic t_flags();
    logic [20:0] tbl [8];
    logic  [1:0] cmd;
    logic        wb, inh;
    logic  [7:0] fl, d;
    tbl = '{{2'h0, 2'h2, 2'h0, 5'h02, 1'h1, 1'h0, 8'h21},
            {2'h0, 2'h2, 2'h2, 5'h01, 1'h0, 1'h0, 8'h01},
            {2'h0, 2'h1, 2'h3, 5'h04, 1'h1, 1'h1, 8'h82},
            {2'h0, 2'h1, 2'h1, 5'h08, 1'h0, 1'h1, 8'h82},
            {2'h0, 2'h0, 2'h0, 5'h11, 1'h0, 1'h1, 8'hC0},
            {2'h0, 2'h0, 2'h0, 5'h01, 1'h0, 1'h0, 8'h40},
            {2'h1, 2'h0, 2'h0, 5'h01, 1'h0, 1'h0, 8'h00},
            {2'h2, 2'h0, 2'h0, 5'h01, 1'h0, 1'h0, 8'h40}};
    for (int i = 0; i < 8; i++) begin
      {cmd, prot, head_sel, spin, wb, inh, fl} = tbl[i];
      spindle_on_cmd  = (cmd == 2'h1);
      spindle_off_cmd = (cmd == 2'h2);
      tick(1);
      spindle_on_cmd  = 1'h0;
      spindle_off_cmd = 1'h0;
      tick(2);
      adapter.rd(`DSBR_ADDR_FLAGS, d);
      chk("hardware flags", d, fl);
      chk("write block", {7'h0, write_block}, {7'h0, wb});
      chk("spindle inhibit", {7'h0, spindle_inhibit}, {7'h0, inh});
    end
    prot = '0;
    spin = '0;
  endtask

  task automatic t_loopback();
    logic [7:0] d;
    adapter.wr_low_cyl(8'h3C);
    adapter.loop_go();
    tick(1);
    chk("cylinder request", {7'h0, lowcyl_req}, 8'h01);
    adapter.wr_low_cyl(8'hC5);
    tick(1);
    chk("echo offer", {6'h0, lowcyl_req, echo_send_req}, 8'h01);
    adapter.wr_low_cyl(8'h77);
    adapter.rd(`DSBR_ADDR_ECHO, d);
    chk("echo byte", d, 8'hC5);
    chk("echo offer", {7'h0, echo_send_req}, 8'h00);
    adapter.rd(`DSBR_ADDR_ECHO, d);
    chk("echo byte", d, 8'hC5);
  endtask

  task automatic t_unmapped();
    logic [7:0] d;
    for (int a = 4; a < 8; a++) begin
      adapter.rd(3'(a), d);
      chk("unmapped byte", d, 8'h00);
    end
  endtask

  initial begin
    resetn           = 1'h0;
    fault_clear      = 1'h0;
    trace_push       = 1'h0;
    fault_trace_code = 8'h00;
    sector64_strap   = 1'h1;
    prot             = '0;
    head_sel         = 2'h0;
    spin             = '0;
    spindle_off_cmd  = 1'h0;
    spindle_on_cmd   = 1'h0;
    t_identity(1'h1);
    t_id_request();
    t_trace();
    t_flags();
    t_loopback();
    t_unmapped();
    t_identity(1'h0);
    complete_run();
  end
endmodule
